// ---- acs_pkg.sv ----
// constants for the adc conversion sequencer
package acs_pkg;
    // register indices on the plain register port
    localparam logic [2:0] REG_INPUT = 3'h0;
    localparam logic [2:0] REG_CONV = 3'h1;
    localparam logic [2:0] REG_EXC = 3'h2;
    localparam logic [2:0] REG_ROUTE = 3'h3;
    localparam logic [2:0] REG_CMD = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    // field positions
    localparam int SEL_LSB = 0;
    localparam int GAIN_LSB = 4;
    localparam int BYP_BIT = 7;
    localparam int RATE_LSB = 0;
    localparam int TURBO_BIT = 3;
    localparam int SINGLE_BIT = 4;
    localparam int REF_LSB = 5;
    localparam int MAG_LSB = 0;
    localparam int PROBE_BIT = 3;
    localparam int R1_LSB = 0;
    localparam int R2_LSB = 3;
    localparam int CMD_START = 0;
    localparam int CMD_SLEEP = 1;
    localparam int CMD_READ = 2;
    // reset values
    localparam logic [7:0] INPUT_RST = 8'h00;
    localparam logic [7:0] CONV_RST = 8'h00;
    localparam logic [7:0] EXC_RST = 8'h00;
    localparam logic [7:0] ROUTE_RST = 8'h00;
    // special input selections and codes
    localparam logic [3:0] SEL_REF_MON = 4'hc;
    localparam logic [3:0] SEL_SUPPLY_MON = 4'hd;
    localparam logic [1:0] SEL_AVSS_TOP = 2'h2;
    localparam logic [2:0] GAIN_ONE = 3'h0;
    localparam logic [2:0] GAIN_FOUR = 3'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [2:0] RATE_FASTEST = 3'h6;
    // timing: clock and oscillator rates in khz
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned OSC_NORMAL_KHZ = 1024;
    localparam int unsigned OSC_TURBO_KHZ = 2048;
    // start-up delay in half oscillator cycles (28.5 and 105 cycles)
    localparam logic [17:0] DLY_NORMAL_HALF = 18'h00039;
    localparam logic [17:0] DLY_TURBO_HALF = 18'h000d2;
    // conversion times in oscillator cycles, slowest rate first
    localparam logic [16:0] CONT_CYC [0:6] = '{17'd51192, 17'd22780, 17'd11532,
        17'd5916, 17'd3116, 17'd1724, 17'd1036};
    localparam logic [16:0] SS_NORMAL_CYC [0:6] = '{17'd51213, 17'd22805, 17'd11557,
        17'd5941, 17'd3141, 17'd1749, 17'd1061};
    localparam logic [16:0] SS_TURBO_CYC [0:6] = '{17'd51217, 17'd22809, 17'd11561,
        17'd5945, 17'd3145, 17'd1753, 17'd1065};
    // excitation magnitudes in microamps, codes 0 to 7, code 0 off
    localparam logic [10:0] EXC_UA [0:7] = '{11'd0, 11'd10, 11'd50, 11'd100,
        11'd250, 11'd500, 11'd1000, 11'd1500};
    localparam logic [10:0] PROBE_UA = 11'd10;
    // sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_DELAY = 2'b01,
        ACS_CONV = 2'b10,
        ACS_SLEEP = 2'b11
    } acs_state_t;
endpackage : acs_pkg

// ---- acs_sequencer.sv ----
// conversion sequencer and analog front-end control of the adc
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
// Function
// - continuous data-ready falls spaced by conversion time
// - start delay 28.5 or 105 cycles
// - single-shot timed from command latch
// - continuous conversion times per data rate
// - single-shot conversion times per mode
// - count at 1.024 or 2.048 MHz
// - start delay added before first continuous period
// - 3-bit field sets excitation magnitude
// - each source routed by own field
// - sources stay on, off on sleep
// - bias on when magnitude nonzero
// - probe sources 10 uA into inputs
// - monitor channel forces bypass, unity gain
// - supply monitor uses internal reference
// - reference monitor uses internal reference
// - timing references the command latch instant
// - modulator clock is oscillator divided four
module acs_sequencer #(
    parameter int unsigned CLK_KHZ = acs_pkg::CLK_KHZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic result_ready_n,
    output logic conv_busy,
    output logic modulator_clk,
    output logic excitation_bias_en,
    output logic [10:0] excitation_ua,
    output logic [2:0] first_source_sel,
    output logic [2:0] second_source_sel,
    output logic first_source_on,
    output logic second_source_on,
    output logic [10:0] probe_ua,
    output logic input_amplifier_bypassed,
    output logic [2:0] eff_gain,
    output logic [1:0] eff_ref_select,
    output logic quarter_scale
);
    // half oscillator cycle increments per clock, in khz
    localparam logic [16:0] INC_NORMAL = 17'(2 * acs_pkg::OSC_NORMAL_KHZ);
    localparam logic [16:0] INC_TURBO = 17'(2 * acs_pkg::OSC_TURBO_KHZ);
    localparam logic [16:0] MODULUS = 17'(CLK_KHZ);

    // reset release through two flops
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // configuration registers
    logic [7:0] input_q, conv_q, exc_q, route_q;
    logic [7:0] rdata_d;
    // field views
    logic [3:0] input_select;
    logic [2:0] gain_cfg, data_rate, excitation_magnitude;
    logic [2:0] first_source_route, second_source_route;
    logic amp_bypass_cfg, turbo, single_shot, open_sensor_probe_en;
    logic [1:0] ref_cfg;
    assign input_select = input_q[acs_pkg::SEL_LSB +: 4];
    assign gain_cfg = input_q[acs_pkg::GAIN_LSB +: 3];
    assign amp_bypass_cfg = input_q[acs_pkg::BYP_BIT];
    assign data_rate = conv_q[acs_pkg::RATE_LSB +: 3];
    assign turbo = conv_q[acs_pkg::TURBO_BIT];
    assign single_shot = conv_q[acs_pkg::SINGLE_BIT];
    assign ref_cfg = conv_q[acs_pkg::REF_LSB +: 2];
    assign excitation_magnitude = exc_q[acs_pkg::MAG_LSB +: 3];
    assign open_sensor_probe_en = exc_q[acs_pkg::PROBE_BIT];
    assign first_source_route = route_q[acs_pkg::R1_LSB +: 3];
    assign second_source_route = route_q[acs_pkg::R2_LSB +: 3];

    // write decode; a command write is the latch instant
    function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] r, input logic w);
        wr_hit = w && (a == r);
    endfunction : wr_hit
    logic start_w, sleep_w, read_w;
    assign start_w = wr_hit(bus_addr, acs_pkg::REG_CMD, bus_wr) && bus_wdata[acs_pkg::CMD_START];
    assign sleep_w = wr_hit(bus_addr, acs_pkg::REG_CMD, bus_wr) && bus_wdata[acs_pkg::CMD_SLEEP];
    assign read_w = wr_hit(bus_addr, acs_pkg::REG_CMD, bus_wr) && bus_wdata[acs_pkg::CMD_READ];

    // config register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_q <= acs_pkg::INPUT_RST;
            conv_q <= acs_pkg::CONV_RST;
            exc_q <= acs_pkg::EXC_RST;
            route_q <= acs_pkg::ROUTE_RST;
        end else begin
            if (wr_hit(bus_addr, acs_pkg::REG_INPUT, bus_wr)) input_q <= bus_wdata;
            if (wr_hit(bus_addr, acs_pkg::REG_CONV, bus_wr)) conv_q <= bus_wdata;
            if (wr_hit(bus_addr, acs_pkg::REG_EXC, bus_wr)) exc_q <= bus_wdata;
            if (wr_hit(bus_addr, acs_pkg::REG_ROUTE, bus_wr)) route_q <= bus_wdata;
        end
    end

    // oscillator emulation: fractional accumulator gives half-cycle ticks
    logic [16:0] acc_q, acc_d, acc_sum;
    logic tick_w;
    assign acc_sum = acc_q + (turbo ? INC_TURBO : INC_NORMAL);
    assign tick_w = acc_sum >= MODULUS;
    // phase restarts at the latch so the count starts there
    assign acc_d = start_w ? 17'h00000 : (tick_w ? acc_sum - MODULUS : acc_sum);

    // sequencer
    acs_pkg::acs_state_t state_q, state_d;
    logic [17:0] cnt_q, cnt_d, term_w, dly_w;
    logic [2:0] rate_idx;
    logic done_w, pre_w, result_ready_n_d;
    // reserved rate code falls back to the fastest setting
    assign rate_idx = (data_rate > acs_pkg::RATE_FASTEST) ? acs_pkg::RATE_FASTEST : data_rate;
    // terms in half cycles, so 28.5 cycles stays exact
    assign term_w = single_shot ?
        {(turbo ? acs_pkg::SS_TURBO_CYC[rate_idx] : acs_pkg::SS_NORMAL_CYC[rate_idx]), 1'b0}
        : {acs_pkg::CONT_CYC[rate_idx], 1'b0};
    assign dly_w = turbo ? acs_pkg::DLY_TURBO_HALF : acs_pkg::DLY_NORMAL_HALF;
    assign done_w = (state_q == acs_pkg::ACS_CONV) && tick_w && (cnt_q == term_w - 18'h1);
    // one half cycle before the end, lift data-ready so it can fall again
    assign pre_w = (state_q == acs_pkg::ACS_CONV) && !single_shot && tick_w
        && (cnt_q == term_w - 18'h2);

    // next state; sleep beats start in the same write
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (sleep_w) begin
            state_d = acs_pkg::ACS_SLEEP;
            cnt_d = 18'h0;
        end else if (start_w) begin
            // single-shot counts from the latch, continuous waits first
            state_d = single_shot ? acs_pkg::ACS_CONV : acs_pkg::ACS_DELAY;
            cnt_d = 18'h0;
        end else begin
            case (state_q)
                acs_pkg::ACS_DELAY: begin
                    if (tick_w && cnt_q == dly_w - 18'h1) begin
                        state_d = acs_pkg::ACS_CONV;
                        cnt_d = 18'h0;
                    end else if (tick_w) cnt_d = cnt_q + 18'h1;
                end
                acs_pkg::ACS_CONV: begin
                    if (done_w) begin
                        // continuous wraps straight into the next period
                        state_d = single_shot ? acs_pkg::ACS_IDLE : acs_pkg::ACS_CONV;
                        cnt_d = 18'h0;
                    end else if (tick_w) cnt_d = cnt_q + 18'h1;
                end
                acs_pkg::ACS_IDLE: cnt_d = 18'h0;
                acs_pkg::ACS_SLEEP: cnt_d = 18'h0;
                default: begin
                    state_d = acs_pkg::ACS_IDLE;
                    cnt_d = 18'h0;
                end
            endcase
        end
    end

    // data-ready: a finished result wins over a read in the same cycle
    assign result_ready_n_d = done_w ? 1'b0 : ((read_w || start_w || pre_w) ? 1'b1 : result_ready_n);

    // modulator phase: four oscillator cycles, eight half ticks
    logic [2:0] mod_q, mod_d;
    logic busy_w;
    assign busy_w = (state_q == acs_pkg::ACS_DELAY) || (state_q == acs_pkg::ACS_CONV);
    assign mod_d = start_w ? 3'h0 : ((tick_w && busy_w) ? mod_q + 3'h1 : mod_q);

    // sequencer flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= acs_pkg::ACS_IDLE;
            cnt_q <= 18'h0;
            acc_q <= 17'h0;
            mod_q <= 3'h0;
            result_ready_n <= 1'b1;
            conv_busy <= 1'b0;
            modulator_clk <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            mod_q <= mod_d;
            result_ready_n <= result_ready_n_d;
            conv_busy <= (state_d == acs_pkg::ACS_DELAY) || (state_d == acs_pkg::ACS_CONV);
            modulator_clk <= mod_d[2];
        end
    end

    // front-end decode
    logic bias_w, monitor_w, avss_w;
    assign bias_w = (excitation_magnitude != 3'h0) && (state_d != acs_pkg::ACS_SLEEP);
    assign monitor_w = (input_select == acs_pkg::SEL_REF_MON)
        || (input_select == acs_pkg::SEL_SUPPLY_MON);
    // single-ended against the low supply also bypasses, gain at most four
    assign avss_w = (input_select[3:2] == acs_pkg::SEL_AVSS_TOP);

    // front-end output flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            excitation_bias_en <= 1'b0;
            excitation_ua <= 11'h0;
            first_source_sel <= 3'h0;
            second_source_sel <= 3'h0;
            first_source_on <= 1'b0;
            second_source_on <= 1'b0;
            probe_ua <= 11'h0;
            input_amplifier_bypassed <= 1'b0;
            eff_gain <= acs_pkg::GAIN_ONE;
            eff_ref_select <= acs_pkg::REF_INTERNAL;
            quarter_scale <= 1'b0;
        end else begin
            excitation_bias_en <= bias_w;
            excitation_ua <= bias_w ? acs_pkg::EXC_UA[excitation_magnitude] : 11'h0;
            first_source_sel <= first_source_route;
            second_source_sel <= second_source_route;
            // current only flows into a routed pin
            first_source_on <= bias_w && (first_source_route != 3'h0);
            second_source_on <= bias_w && (second_source_route != 3'h0);
            probe_ua <= open_sensor_probe_en ? acs_pkg::PROBE_UA : 11'h0;
            input_amplifier_bypassed <= monitor_w || avss_w || amp_bypass_cfg;
            if (monitor_w) eff_gain <= acs_pkg::GAIN_ONE;
            else if (avss_w && gain_cfg > acs_pkg::GAIN_FOUR) eff_gain <= acs_pkg::GAIN_FOUR;
            else eff_gain <= gain_cfg;
            eff_ref_select <= monitor_w ? acs_pkg::REF_INTERNAL : ref_cfg;
            quarter_scale <= monitor_w;
        end
    end

    // read mux; status shows live sequencer state, unmapped reads zero
    always_comb begin
        case (bus_addr)
            acs_pkg::REG_INPUT: rdata_d = input_q;
            acs_pkg::REG_CONV: rdata_d = conv_q;
            acs_pkg::REG_EXC: rdata_d = exc_q;
            acs_pkg::REG_ROUTE: rdata_d = route_q;
            acs_pkg::REG_STATUS: rdata_d = {4'h0, excitation_bias_en,
                state_q == acs_pkg::ACS_SLEEP, conv_busy, !result_ready_n};
            default: rdata_d = 8'h00;
        endcase
    end
    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) bus_rdata <= 8'h00;
        else bus_rdata <= bus_rd ? rdata_d : 8'h00;
    end

    // checks
    // shortest tick spacing in clocks; the longest is one more
    localparam int GAP_N_LO = int'(CLK_KHZ / (2 * acs_pkg::OSC_NORMAL_KHZ));
    localparam int GAP_T_LO = int'(CLK_KHZ / (2 * acs_pkg::OSC_TURBO_KHZ));
    // helper: clocks since the latest tick or latch
    logic [7:0] gap_q;
    // a mode change leaves a stray phase, so spacing is judged after a rebase
    logic gap_ok_q, turbo_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 8'h00;
            gap_ok_q <= 1'b1;
            turbo_q <= 1'b0;
        end else begin
            gap_q <= (tick_w || start_w) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
            gap_ok_q <= start_w || ((turbo == turbo_q) && (tick_w || gap_ok_q));
            turbo_q <= turbo;
        end
    end
    // last count of a period, then data-ready falls
    sequence conv_end_s;
        (cnt_q == term_w - 18'h1) ##1 $fell(result_ready_n);
    endsequence
    tick_normal_a: assert property (@(posedge clk) disable iff (!rst_n)
        (gap_ok_q && !turbo && !turbo_q) |-> (tick_w
        ? (gap_q >= GAP_N_LO - 1 && gap_q <= GAP_N_LO) : (gap_q < GAP_N_LO)))
        else $error("normal oscillator tick spacing wrong");
    tick_turbo_a: assert property (@(posedge clk) disable iff (!rst_n)
        (gap_ok_q && turbo && turbo_q) |-> (tick_w
        ? (gap_q >= GAP_T_LO - 1 && gap_q <= GAP_T_LO) : (gap_q < GAP_T_LO)))
        else $error("turbo oscillator tick spacing wrong");
    conv_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        done_w |-> conv_end_s)
        else $error("conversion end without data-ready fall");
    start_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == acs_pkg::ACS_DELAY && state_d == acs_pkg::ACS_CONV && !start_w)
        |-> cnt_q == dly_w - 18'h1) else $error("start delay length wrong");
    single_path_a: assert property (@(posedge clk) disable iff (!rst_n)
        (start_w && !sleep_w && single_shot) |=> state_q == acs_pkg::ACS_CONV && cnt_q == 18'h0)
        else $error("single-shot not counted from latch");
    rdy_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        (read_w && !done_w) |=> result_ready_n) else $error("data-ready not released on read");
    bias_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 excitation_bias_en == $past(bias_w)) else $error("bias enable mismatch");
    sleep_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_w |=> !excitation_bias_en && !first_source_on && !second_source_on)
        else $error("sources not powered down on sleep");
    route_flow_a: assert property (@(posedge clk) disable iff (!rst_n)
        first_source_on |-> excitation_bias_en && first_source_sel != 3'h0)
        else $error("current flows without route");
    monitor_gain_a: assert property (@(posedge clk) disable iff (!rst_n)
        monitor_w |=> input_amplifier_bypassed && eff_gain == acs_pkg::GAIN_ONE
        && eff_ref_select == acs_pkg::REF_INTERNAL) else $error("monitor override missing");
    mod_div_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick_w && busy_w && !start_w && mod_q == 3'h3) |=> $rose(modulator_clk))
        else $error("modulator clock phase wrong");
endmodule : acs_sequencer

// ---- acs_host_model.sv ----
// host model driving the register port of the sequencer
`timescale 1ns/10ps
module acs_host_model (
    input wire logic clk,
    output logic [2:0] bus_addr,
    output logic [7:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd
);
    // quiet bus at time zero
    initial begin
        bus_addr = 3'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    // one access taken at the second edge
    // released lines show the inverse so a stale value never matches
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= w;
        bus_rd <= !w;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask : access
    // magnitude first, source start-up wait, routing after
    task automatic set_exc(input logic [2:0] m, input logic [2:0] r1, input logic [2:0] r2);
        access(1'b1, acs_pkg::REG_EXC, {5'h00, m});
        repeat (8000) @(posedge clk);
        access(1'b1, acs_pkg::REG_ROUTE, {2'h0, r2, r1});
    endtask : set_exc
endmodule : acs_host_model

// ---- acs_sequencer_tb_top.sv ----
// self-checking bench of the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_tb_top;
    localparam int unsigned CLK_KHZ = 4097; // fewer clocks per tick, short run
    localparam int TOL = 4; // tick jitter plus output flops
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    logic result_ready_n;
    logic conv_busy;
    logic modulator_clk;
    logic excitation_bias_en;
    logic [10:0] excitation_ua;
    logic [2:0] first_source_sel;
    logic [2:0] second_source_sel;
    logic first_source_on;
    logic second_source_on;
    logic [10:0] probe_ua;
    logic input_amplifier_bypassed;
    logic [2:0] eff_gain;
    logic [1:0] eff_ref_select;
    logic quarter_scale;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0; // time base of latches and falls
    int fall_cyc = 0; // cycle of latest ready fall
    int n_falls = 0;
    int mod_rise = 0;
    int mod_per = 0; // latest modulator period in clocks
    logic rd_d = 1'b0;
    logic rdy_d = 1'b1;
    logic mod_d = 1'b0;
    logic [7:0] lfsr_q = 8'h1b; // seed 27
    logic [7:0] exp_q [$]; // expected read data, oldest first
    logic [10:0] ua_tab [0:7] = '{11'h000, 11'h00a, 11'h032, 11'h064,
        11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc};
    // free running clock
    always #12.5 clk = ~clk;
    acs_sequencer #(.CLK_KHZ(CLK_KHZ)) u_dut (.clk(clk), .rstn(rstn),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .result_ready_n(result_ready_n),
        .conv_busy(conv_busy), .modulator_clk(modulator_clk),
        .excitation_bias_en(excitation_bias_en), .excitation_ua(excitation_ua),
        .first_source_sel(first_source_sel), .second_source_sel(second_source_sel),
        .first_source_on(first_source_on), .second_source_on(second_source_on),
        .probe_ua(probe_ua), .input_amplifier_bypassed(input_amplifier_bypassed),
        .eff_gain(eff_gain), .eff_ref_select(eff_ref_select),
        .quarter_scale(quarter_scale));
    acs_host_model u_host (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd));
    // verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // value compare, four-state exact
    task automatic chk_bits(input string nm, input logic [10:0] e, input logic [10:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bits
    // time compare within tick jitter
    task automatic chk_time(input string nm, input int e, input int g);
        n_checks++;
        if (g > e + TOL || g + TOL < e) begin
            mismatches++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_time
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    // half oscillator ticks to clocks of this bench
    function automatic int clocks(input int h, input logic turbo);
        return h * CLK_KHZ / (turbo ? 4096 : 2048);
    endfunction : clocks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d);
    endtask : wr
    // note the expected answer, then read
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.access(1'b0, a, 8'h00);
    endtask : rd_chk
    // register plus output flop latency
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle
    // start and time the first ready fall, and the next spacing if asked
    task automatic timed(input logic [7:0] cfg, input int h1, input int h2);
        int t0;
        int f0;
        wr(acs_pkg::REG_CONV, cfg);
        wr(acs_pkg::REG_CMD, 8'h01);
        t0 = cyc;
        f0 = n_falls;
        settle();
        chk_bits("busy", 11'h001, {10'h000, conv_busy});
        for (int i = 0; i < 120000 && n_falls == f0; i++) begin
            @(posedge clk);
        end
        chk_time("first result", clocks(h1, cfg[3]), fall_cyc - t0);
        if (h2 != 0) begin
            t0 = fall_cyc;
            for (int i = 0; i < 120000 && n_falls == f0 + 1; i++) begin
                @(posedge clk);
            end
            chk_time("ready spacing", clocks(h2, cfg[3]), fall_cyc - t0);
        end
    endtask : timed
    // watcher: read answers, ready falls, modulator period
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_d <= bus_rd;
        rdy_d <= result_ready_n;
        mod_d <= modulator_clk;
        if (rd_d && exp_q.size() > 0) begin
            chk_bits("read data", {3'h0, exp_q.pop_front()}, {3'h0, bus_rdata});
        end
        if (rdy_d === 1'b1 && result_ready_n === 1'b0) begin
            fall_cyc <= cyc;
            n_falls <= n_falls + 1;
        end
        if (mod_d === 1'b0 && modulator_clk === 1'b1) begin
            mod_per <= cyc - mod_rise;
            mod_rise <= cyc;
        end
    end
    // watchdog well past the expected run length
    initial begin
        #(25 * 80000);
        mismatches++;
        end_sim();
    end
    // main sequence
    initial begin
        logic mon;
        logic se;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk_bits("ready idle", 11'h001, {10'h000, result_ready_n});
        for (int a = 0; a < 8; a++) begin
            rd_chk(a[2:0], 8'h00);
        end
        // random readback of the config registers
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(i[2:0], lfsr_q);
            // config registers keep the whole byte, spare bits included
            rd_chk(i[2:0], lfsr_q);
        end
        // every magnitude code with both sources unrouted
        wr(acs_pkg::REG_ROUTE, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr(acs_pkg::REG_EXC, {5'h00, m[2:0]});
            settle();
            chk_bits("magnitude", ua_tab[m], excitation_ua);
            chk_bits("bias", {10'h000, m != 0}, {10'h000, excitation_bias_en});
            chk_bits("first on", 11'h000, {10'h000, first_source_on});
        end
        // both sources to one pin, then random routes
        u_host.set_exc(3'h7, 3'h5, 3'h5);
        settle();
        chk_bits("same pin", 11'h0ed, {3'h0, first_source_on, second_source_on,
            first_source_sel, second_source_sel});
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(acs_pkg::REG_ROUTE, {2'h0, lfsr_q[5:0]});
            settle();
            chk_bits("second route", {8'h00, lfsr_q[5:3]}, {8'h00, second_source_sel});
            chk_bits("first on", {10'h000, lfsr_q[2:0] != 3'h0},
                {10'h000, first_source_on});
        end
        // fault probe on only for the test
        wr(acs_pkg::REG_EXC, 8'h0f);
        settle();
        chk_bits("probe", 11'h00a, probe_ua);
        wr(acs_pkg::REG_EXC, 8'h07);
        settle();
        chk_bits("probe off", 11'h000, probe_ua);
        // all input selections, gain 7, external reference code 3
        wr(acs_pkg::REG_CONV, 8'h60);
        for (int s = 0; s < 16; s++) begin
            mon = (s == 12) || (s == 13);
            se = (s >= 8) && (s <= 11);
            wr(acs_pkg::REG_INPUT, {4'h7, s[3:0]});
            settle();
            chk_bits("bypass", {10'h000, mon | se}, {10'h000, input_amplifier_bypassed});
            chk_bits("gain", mon ? 11'h000 : (se ? 11'h002 : 11'h007), {8'h00, eff_gain});
            chk_bits("reference", mon ? 11'h000 : 11'h003, {9'h000, eff_ref_select});
            chk_bits("quarter", {10'h000, mon}, {10'h000, quarter_scale});
        end
        // conversion timing, continuous then single-shot
        timed(8'h06, 57 + 2 * 1036, 2 * 1036);
        chk_time("modulator", clocks(8, 1'b0), mod_per);
        timed(8'h0e, 210 + 2 * 1036, 2 * 1036);
        chk_time("modulator", clocks(8, 1'b1), mod_per);
        timed(8'h15, 2 * 1749, 0);
        timed(8'h16, 2 * 1061, 0);
        timed(8'h1e, 2 * 1065, 0);
        // result held, sources kept, then read and sleep
        repeat (40) @(posedge clk);
        chk_bits("ready held", 11'h000, {10'h000, result_ready_n});
        chk_bits("bias kept", 11'h001, {10'h000, excitation_bias_en});
        wr(acs_pkg::REG_CMD, 8'h04);
        settle();
        chk_bits("ready read", 11'h001, {10'h000, result_ready_n});
        wr(acs_pkg::REG_CMD, 8'h02);
        settle();
        chk_bits("sleep bias", 11'h000, {10'h000, excitation_bias_en});
        rd_chk(acs_pkg::REG_STATUS, 8'h04);
        settle();
        end_sim();
    end
endmodule : acs_sequencer_tb_top
